/* rtl/ptsr_consts.svh */
// Register map, buffer layout, reset values and timing counts of the timing block
`ifndef PTSR_CONSTS_SVH
`define PTSR_CONSTS_SVH
`define PTSR_AW 13
`define PTSR_REG_TXREQ 13'h000
`define PTSR_REG_RXPTR 13'h004
`define PTSR_REG_INCR 13'h008
`define PTSR_REG_ADJNS 13'h00c
`define PTSR_REG_ADJSECLO 13'h010
`define PTSR_REG_ADJSECHI 13'h014
`define PTSR_REG_ADJGO 13'h018
`define PTSR_REG_NS 13'h01c
`define PTSR_REG_SECLO 13'h020
`define PTSR_REG_SECHI 13'h024
`define PTSR_REG_SWRST 13'h028
`define PTSR_TXBUF_BASE 13'h0400
`define PTSR_TXBUF_MASK 13'h1e00
`define PTSR_TXTS_BASE 13'h0600
`define PTSR_TXTS_MASK 13'h1fe0
`define PTSR_RXBUF_BASE 13'h0800
`define PTSR_RXBUF_MASK 13'h1c00
`define PTSR_RXTS_BASE 13'h0c00
`define PTSR_RXTS_MASK 13'h1fc0
`define PTSR_TPL_MAX 3'h6
`define PTSR_LAST_BYTE 6'h3f
`define PTSR_BYTE_LIMIT 7'h40
`define PTSR_TYPE_HI_BYTE 7'h0c
`define PTSR_TYPE_LO_BYTE 7'h0d
`define PTSR_ETYPE 16'h88f7
`define PTSR_ETYPE_HI 8'h88
`define PTSR_ETYPE_LO 8'hf7
`define PTSR_NS_PER_SEC 33'h03b9aca00
`define PTSR_NS_TWO_SEC 33'h077359400
`define PTSR_CLK_PERIOD_NS 50
`define PTSR_FRAC_BITS 20
`define PTSR_INCR_RST (32'(`PTSR_CLK_PERIOD_NS) << `PTSR_FRAC_BITS)
`define PTSR_TPL_W0 32'h00c28001
`define PTSR_TPL_W1 32'h00000e00
`define PTSR_TPL_VER 8'h02
`endif

/* rtl/ptsr_pkg.sv */
// Types shared by the timing block
package ptsr_pkg;
  typedef struct packed {
    logic [12:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ptsr_bus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } ptsr_tx_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic good;
    logic bad;
  } ptsr_rx_t;

  typedef struct packed {
    logic [6:0][15:0][31:0] txMem;
    logic [6:0][31:0] txTs;
    logic [15:0][15:0][31:0] rxMem;
    logic [15:0][31:0] rxTs;
    logic txPend;
    logic [2:0] txSel;
    logic txActive;
    logic [5:0] txCnt;
    logic [2:0] txTmpl;
    logic [31:0] txTsCap;
    logic [7:0] txData;
    logic txValid;
    logic txIrq;
    logic rxActive;
    logic [6:0] rxCnt;
    logic [15:0] rxType;
    logic [31:0] rxTsCap;
    logic [3:0] rxNewest;
    logic rxIrq;
    logic [31:0] incr;
    logic [31:0] adjNs;
    logic [47:0] adjSec;
    logic [31:0] ns;
    logic [19:0] frac;
    logic [47:0] sec;
    logic [47:0] snapSec;
    logic [31:0] rdData;
    logic txReset;
    logic rxReset;
  } ptsr_state_t;
endpackage

/* rtl/ptsr_top.sv */
// Timing packet buffers, timestamps and real time counter
`timescale 1ns/1ps
`include "ptsr_consts.svh"

// Behaviour
// - Seven preloaded templates, bus readable and writable
// - Register selects template to transmit
// - Pulse transmit interrupt after each frame
// - Capture nanoseconds into template timestamp word
// - Transmit timestamp stored before interrupt
// - Sixteen receive frame slots, bus readable
// - Pulse receive interrupt per stored frame
// - Circular overwrite, register shows newest slot
// - Receive timestamp stored before interrupt
// - Nanoseconds count one second then zero
// - 48-bit seconds carry, wrap at saturation
// - Add increment each cycle, 2^-20 ns units
// - Step register applies one-time counter change
// - One reset clears the block, loads increment, pointer, templates
// - Transmit, receive logic qualified by enables
// - Software request drives transmit path reset
// - Software request drives receive path reset
// - Timing frames recognised by length/type value
module ptsr_top (
  input wire logic mclk,
  input wire logic reset,
  input wire ptsr_pkg::ptsr_bus_req_t busReq,
  output logic [31:0] rdData,
  input wire logic txClkEn,
  input wire logic txAck,
  output ptsr_pkg::ptsr_tx_t txOut,
  output logic txIrq,
  input wire logic rxClkEn,
  input wire ptsr_pkg::ptsr_rx_t rxIn,
  output logic rxIrq,
  output logic txReset,
  output logic rxReset
);
  ptsr_pkg::ptsr_state_t st_ff;
  ptsr_pkg::ptsr_state_t nxt_st;

  logic stepGo;
  assign stepGo = busReq.wr && busReq.addr == `PTSR_REG_ADJGO;

  always_comb begin
    logic [52:0] acc;
    logic [32:0] nsSum;
    logic [47:0] secInc;
    logic [31:0] word;
    logic [3:0] rxSlot;
    logic [12:0] a;
    acc = '0;
    nsSum = '0;
    secInc = '0;
    word = '0;
    a = busReq.addr;
    rxSlot = st_ff.rxNewest + 4'h1;
    nxt_st = st_ff;
    nxt_st.txIrq = 1'b0;
    nxt_st.rxIrq = 1'b0;
    nxt_st.rdData = 32'h0;

    // Counter: fraction kept so rate trims below 1 ns per cycle
    acc = {1'b0, st_ff.ns, st_ff.frac} + 53'(st_ff.incr);
    nsSum = acc[52:20] + (stepGo ? {1'b0, st_ff.adjNs} : 33'h0);
    if (nsSum >= `PTSR_NS_TWO_SEC) begin
      nxt_st.ns = 32'(nsSum - `PTSR_NS_TWO_SEC);
      secInc = 48'h2;
    end else if (nsSum >= `PTSR_NS_PER_SEC) begin
      nxt_st.ns = 32'(nsSum - `PTSR_NS_PER_SEC);
      secInc = 48'h1;
    end else begin
      nxt_st.ns = nsSum[31:0];
    end
    nxt_st.frac = acc[19:0];
    nxt_st.sec = st_ff.sec + secInc + (stepGo ? st_ff.adjSec : 48'h0);

    if (busReq.wr) begin
      case (a)
        `PTSR_REG_TXREQ: begin
          if (!st_ff.txPend && busReq.wdata[2:0] <= `PTSR_TPL_MAX) begin
            nxt_st.txPend = 1'b1;
            nxt_st.txSel = busReq.wdata[2:0];
          end
        end
        `PTSR_REG_INCR: nxt_st.incr = busReq.wdata;
        `PTSR_REG_ADJNS: nxt_st.adjNs = busReq.wdata;
        `PTSR_REG_ADJSECLO: nxt_st.adjSec[31:0] = busReq.wdata;
        `PTSR_REG_ADJSECHI: nxt_st.adjSec[47:32] = busReq.wdata[15:0];
        `PTSR_REG_SWRST: begin
          nxt_st.txReset = busReq.wdata[0];
          nxt_st.rxReset = busReq.wdata[1];
        end
        default: begin
          if ((a & `PTSR_TXBUF_MASK) == `PTSR_TXBUF_BASE && a[8:6] <= `PTSR_TPL_MAX) begin
            nxt_st.txMem[a[8:6]][a[5:2]] = busReq.wdata;
          end
        end
      endcase
    end

    if (busReq.rd) begin
      case (a)
        `PTSR_REG_TXREQ: nxt_st.rdData = {27'h0, st_ff.txActive, st_ff.txPend, st_ff.txSel};
        `PTSR_REG_RXPTR: nxt_st.rdData = {28'h0, st_ff.rxNewest};
        `PTSR_REG_INCR: nxt_st.rdData = st_ff.incr;
        `PTSR_REG_ADJNS: nxt_st.rdData = st_ff.adjNs;
        `PTSR_REG_ADJSECLO: nxt_st.rdData = st_ff.adjSec[31:0];
        `PTSR_REG_ADJSECHI: nxt_st.rdData = {16'h0, st_ff.adjSec[47:32]};
        `PTSR_REG_NS: begin
          // Seconds frozen here so a split read never tears
          nxt_st.rdData = st_ff.ns;
          nxt_st.snapSec = st_ff.sec;
        end
        `PTSR_REG_SECLO: nxt_st.rdData = st_ff.snapSec[31:0];
        `PTSR_REG_SECHI: nxt_st.rdData = {16'h0, st_ff.snapSec[47:32]};
        `PTSR_REG_SWRST: nxt_st.rdData = {30'h0, st_ff.rxReset, st_ff.txReset};
        default: begin
          if ((a & `PTSR_TXBUF_MASK) == `PTSR_TXBUF_BASE && a[8:6] <= `PTSR_TPL_MAX) begin
            nxt_st.rdData = st_ff.txMem[a[8:6]][a[5:2]];
          end else if ((a & `PTSR_TXTS_MASK) == `PTSR_TXTS_BASE && a[4:2] <= `PTSR_TPL_MAX) begin
            nxt_st.rdData = st_ff.txTs[a[4:2]];
          end else if ((a & `PTSR_RXBUF_MASK) == `PTSR_RXBUF_BASE) begin
            nxt_st.rdData = st_ff.rxMem[a[9:6]][a[5:2]];
          end else if ((a & `PTSR_RXTS_MASK) == `PTSR_RXTS_BASE) begin
            nxt_st.rdData = st_ff.rxTs[a[5:2]];
          end
        end
      endcase
    end

    // Transmit engine, advances only on enabled cycles
    if (txClkEn) begin
      if (!st_ff.txActive) begin
        if (st_ff.txPend) begin
          nxt_st.txActive = 1'b1;
          nxt_st.txPend = 1'b0;
          nxt_st.txTmpl = st_ff.txSel;
          nxt_st.txCnt = 6'h0;
          nxt_st.txValid = 1'b1;
          nxt_st.txData = st_ff.txMem[st_ff.txSel][0][7:0];
        end
      end else if (txAck) begin
        if (st_ff.txCnt == 6'h0) begin
          nxt_st.txTsCap = st_ff.ns;
        end
        if (st_ff.txCnt == `PTSR_LAST_BYTE) begin
          nxt_st.txActive = 1'b0;
          nxt_st.txValid = 1'b0;
          nxt_st.txTs[st_ff.txTmpl] = st_ff.txTsCap;
          nxt_st.txIrq = 1'b1;
        end else begin
          nxt_st.txCnt = st_ff.txCnt + 6'h1;
          word = st_ff.txMem[st_ff.txTmpl][nxt_st.txCnt[5:2]];
          nxt_st.txData = word[{nxt_st.txCnt[1:0], 3'b000} +: 8];
        end
      end
    end

    // Receive: bytes land in the oldest slot, committed only if timing frame
    if (rxClkEn) begin
      if (rxIn.valid) begin
        if (!st_ff.rxActive) begin
          nxt_st.rxActive = 1'b1;
          nxt_st.rxTsCap = st_ff.ns;
          nxt_st.rxCnt = 7'h1;
          nxt_st.rxMem[rxSlot][0][7:0] = rxIn.data;
        end else if (st_ff.rxCnt < `PTSR_BYTE_LIMIT) begin
          nxt_st.rxMem[rxSlot][st_ff.rxCnt[5:2]][{st_ff.rxCnt[1:0], 3'b000} +: 8] = rxIn.data;
          nxt_st.rxCnt = st_ff.rxCnt + 7'h1;
          if (st_ff.rxCnt == `PTSR_TYPE_HI_BYTE) begin
            nxt_st.rxType[15:8] = rxIn.data;
          end
          if (st_ff.rxCnt == `PTSR_TYPE_LO_BYTE) begin
            nxt_st.rxType[7:0] = rxIn.data;
          end
        end
      end else if (st_ff.rxActive && (rxIn.good || rxIn.bad)) begin
        nxt_st.rxActive = 1'b0;
        nxt_st.rxType = 16'h0;
        if (rxIn.good && st_ff.rxType == `PTSR_ETYPE) begin
          nxt_st.rxNewest = rxSlot;
          nxt_st.rxTs[rxSlot] = st_ff.rxTsCap;
          nxt_st.rxIrq = 1'b1;
        end
      end
    end

    if (reset) begin
      nxt_st = '0;
      nxt_st.incr = `PTSR_INCR_RST;
      nxt_st.rxNewest = 4'hf;
      for (int t = 0; t <= 6; t++) begin
        nxt_st.txMem[t][0] = `PTSR_TPL_W0;
        nxt_st.txMem[t][1] = `PTSR_TPL_W1;
        nxt_st.txMem[t][3] = {`PTSR_TPL_VER, 5'h00, 3'(t), `PTSR_ETYPE_LO, `PTSR_ETYPE_HI};
      end
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign rdData = st_ff.rdData;
  assign txOut = {st_ff.txData, st_ff.txValid};
  assign txIrq = st_ff.txIrq;
  assign rxIrq = st_ff.rxIrq;
  assign txReset = st_ff.txReset;
  assign rxReset = st_ff.rxReset;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  nsRange_check_a: assert property (st_ff.ns < 32'h3b9aca00)
    else $error("nanoseconds out of range");
  sec_carry_a: assert property ((st_ff.ns < $past(st_ff.ns)) && !$past(stepGo) && !$past(reset)
    |-> st_ff.sec == $past(st_ff.sec) + 48'h1)
    else $error("seconds did not carry");
  ns_advance_a: assert property (!stepGo && st_ff.ns < 32'h3b9ac000
    |=> {st_ff.ns, st_ff.frac} == $past({st_ff.ns, st_ff.frac}) + 52'($past(st_ff.incr)))
    else $error("counter step wrong");
  tx_ts_ready_a: assert property (txIrq |-> st_ff.txTs[st_ff.txTmpl] == st_ff.txTsCap
    && !txOut.valid)
    else $error("tx timestamp not stored");
  rx_ts_ready_a: assert property (rxIrq |-> st_ff.rxTs[st_ff.rxNewest] == st_ff.rxTsCap)
    else $error("rx timestamp not stored");
  rx_pointer_a: assert property (rxIrq |-> st_ff.rxNewest == $past(st_ff.rxNewest) + 4'h1)
    else $error("newest pointer not advanced");
  tx_gate_a: assert property (!txClkEn |=> $stable(st_ff.txCnt) && !txIrq)
    else $error("tx moved without enable");
  rx_gate_a: assert property (!rxClkEn |=> $stable(st_ff.rxCnt) && !rxIrq)
    else $error("rx moved without enable");
  tx_rst_out_a: assert property (busReq.wr && busReq.addr == `PTSR_REG_SWRST
    |=> txReset == $past(busReq.wdata[0]) && rxReset == $past(busReq.wdata[1]))
    else $error("path reset not driven");
  tx_irq_pulse_a: assert property (txIrq |=> !txIrq)
    else $error("tx irq longer than one cycle");

  txDone_c: cover property (txIrq);
  rxStore_c: cover property (rxIrq);
  secWrap_c: cover property (st_ff.ns < $past(st_ff.ns));
  stepApplied_c: cover property (stepGo);
endmodule

/* test/ptsr_mac_model.sv */
// Behavioural MAC client side: acknowledges transmit bytes, sends receive frames
`timescale 1ns/1ps
module ptsr_mac_model (
  input wire logic mclk,
  input wire ptsr_pkg::ptsr_tx_t txOut,
  input wire logic txClkEn,
  input wire logic rxClkEn,
  input wire logic slowAck,
  output logic txAck,
  output ptsr_pkg::ptsr_rx_t rxIn
);
  logic [7:0] txBytes [64];
  int txIdx = 0;
  initial begin
    txAck = 1'b0;
    rxIn = '0;
  end
  // Slow mode acks every other cycle so the block must hold its byte
  always @(posedge mclk) begin
    if (txOut.valid && txAck && txClkEn) begin
      txBytes[txIdx % 64] <= txOut.data;
      txIdx <= txIdx + 1;
    end
    txAck <= txOut.valid && !(slowAck && txAck);
  end
  task automatic sendFrame(input logic [15:0] eType, input logic ok);
    @(posedge mclk);
    for (int k = 0; k < 65; k++) begin
      rxIn.valid <= k < 64;
      rxIn.data <= k == 12 ? eType[15:8] : k == 13 ? eType[7:0] : 8'(k);
      rxIn.good <= k == 64 && ok;
      rxIn.bad <= k == 64 && !ok;
      do @(posedge mclk); while (!rxClkEn);
    end
    rxIn <= '0;
  endtask
endmodule

/* test/ptsr_top_tb.sv */
// Self-checking bench for the timing block
`timescale 1ns/1ps
`include "ptsr_consts.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin badCount++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module ptsr_top_tb;
  logic mclk, reset, txClkEn, rxClkEn, slowAck, txAck, txIrq, rxIrq, txReset, rxReset;
  ptsr_pkg::ptsr_bus_req_t busReq;
  ptsr_pkg::ptsr_tx_t txOut;
  ptsr_pkg::ptsr_rx_t rxIn;
  logic [31:0] rdData, rv, ns0;
  int badCount = 0, samplesChecked = 0, cyc = 0, txIrqs = 0, rxIrqs = 0;
  ptsr_top dut (.mclk(mclk), .reset(reset), .busReq(busReq), .rdData(rdData),
    .txClkEn(txClkEn), .txAck(txAck), .txOut(txOut), .txIrq(txIrq), .rxClkEn(rxClkEn),
    .rxIn(rxIn), .rxIrq(rxIrq), .txReset(txReset), .rxReset(rxReset));
  ptsr_mac_model mac (.mclk(mclk), .txOut(txOut), .txClkEn(txClkEn), .rxClkEn(rxClkEn),
    .slowAck(slowAck), .txAck(txAck), .rxIn(rxIn));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Enables drop one cycle in three so held transfers get exercised
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    txClkEn <= (cyc % 3) != 1;
    rxClkEn <= (cyc % 3) != 2;
    txIrqs <= txIrqs + int'(txIrq);
    rxIrqs <= rxIrqs + int'(rxIrq);
  end
  function automatic logic [7:0] pat(int k);
    return 8'(k * 7 + 3);
  endfunction
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic busWr(input logic [12:0] a, input logic [31:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask
  task automatic busRd(input logic [12:0] a, output logic [31:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask
  task automatic rc(input logic [12:0] a, input logic [31:0] e);
    busRd(a, rv);
    `CHK(rv, e)
  endtask
  task automatic waitIrq(input bit tx, input int want);
    int k;
    for (k = 0; k < 600 && (tx ? txIrqs : rxIrqs) < want; k++) @(posedge mclk);
    if (k == 600) begin
      badCount++;
      $display("ERROR %0t: interrupt timeout", $time);
      summarize();
    end
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    $display("ERROR %0t: run timeout", $time);
    summarize();
  end
  initial begin
    busReq = '0;
    reset = 1'b1;
    txClkEn = 1'b0;
    rxClkEn = 1'b0;
    slowAck = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rc(`PTSR_REG_INCR, `PTSR_INCR_RST);
    rc(`PTSR_REG_RXPTR, 32'h0000000f);
    rc(13'h03fc, 32'h00000000);
    for (int i = 1; i >= 0; i--) begin
      busWr(`PTSR_REG_INCR, i ? 32'h03280000 : `PTSR_INCR_RST);
      busRd(`PTSR_REG_NS, ns0);
      busRd(`PTSR_REG_NS, rv);
      `CHK(rv - ns0, i ? 32'd101 : 32'd100)
    end
    busRd(`PTSR_REG_NS, ns0);
    busWr(`PTSR_REG_ADJSECLO, 32'hffffffff);
    busWr(`PTSR_REG_ADJSECHI, 32'h0000ffff);
    busWr(`PTSR_REG_ADJNS, 32'd999990000 - ns0);
    busWr(`PTSR_REG_ADJGO, 32'h1);
    busRd(`PTSR_REG_NS, rv);
    `CHK(rv > 32'd999990000, 1'b1)
    rc(`PTSR_REG_SECLO, 32'hffffffff);
    rc(`PTSR_REG_SECHI, 32'h0000ffff);
    repeat (300) @(posedge mclk);
    busRd(`PTSR_REG_NS, rv);
    `CHK(rv < 32'd20000, 1'b1)
    rc(`PTSR_REG_SECLO, 32'h0);
    rc(`PTSR_REG_SECHI, 32'h0);
    for (int w = 0; w < 16; w++) begin
      busWr(`PTSR_TXBUF_BASE + 13'h080 + 13'(w * 4),
        {pat(4 * w + 3), pat(4 * w + 2), pat(4 * w + 1), pat(4 * w)});
    end
    rc(`PTSR_TXBUF_BASE + 13'h0bc, {pat(63), pat(62), pat(61), pat(60)});
    slowAck <= 1'b1;
    busRd(`PTSR_REG_NS, ns0);
    busWr(`PTSR_REG_TXREQ, 32'h2);
    waitIrq(1'b1, 1);
    busRd(`PTSR_TXTS_BASE + 13'h008, rv);
    `CHK(rv - ns0 < 32'd2000, 1'b1)
    `CHK(mac.txIdx, 64)
    for (int k = 0; k < 64; k++) `CHK(mac.txBytes[k], pat(k))
    busWr(`PTSR_REG_TXREQ, 32'h7);
    busRd(`PTSR_REG_TXREQ, rv);
    `CHK(rv[4:3], 2'b00)
    `CHK(txIrqs, 1)
    busRd(`PTSR_REG_NS, ns0);
    mac.sendFrame(16'h88f7, 1'b1);
    waitIrq(1'b0, 1);
    rc(`PTSR_REG_RXPTR, 32'h0);
    rc(`PTSR_RXBUF_BASE + 13'h00c, 32'h0f0ef788);
    busRd(`PTSR_RXTS_BASE, rv);
    `CHK(rv - ns0 < 32'd2000, 1'b1)
    mac.sendFrame(16'h0800, 1'b1);
    mac.sendFrame(16'h88f7, 1'b0);
    repeat (4) @(posedge mclk);
    `CHK(rxIrqs, 1)
    for (int f = 0; f < 15; f++) mac.sendFrame(16'h88f7, 1'b1);
    waitIrq(1'b0, 16);
    rc(`PTSR_REG_RXPTR, 32'hf);
    for (int i = 1; i < 4; i++) begin
      busWr(`PTSR_REG_SWRST, 32'(i % 3));
      repeat (2) @(posedge mclk);
      #1 `CHK({rxReset, txReset}, 2'(i % 3))
    end
    summarize();
  end
endmodule
